// ### rtl/mpcm_pkg.sv
// Shared constants for the multichannel serial highway core
`default_nettype none
package mpcm_pkg;
  localparam int NCH = 32;
  localparam int RB_DEPTH = 64;
  localparam int TB_DEPTH = 64;
  // Register byte offsets
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_STAT   = 12'h004;
  localparam logic [11:0] A_MASK   = 12'h008;
  localparam logic [11:0] A_RXCNT  = 12'h00c;
  localparam logic [11:0] A_RXDATA = 12'h010;
  localparam logic [11:0] A_RXCH   = 12'h014;
  localparam logic [11:0] A_TXREQ  = 12'h018;
  localparam logic [11:0] A_TXDATA = 12'h01c;
  localparam logic [11:0] A_TXSEL  = 12'h020;
  localparam logic [11:0] A_TXDONE = 12'h024;
  localparam logic [11:0] A_SLOT   = 12'h100;
  localparam logic [11:0] A_CHAN   = 12'h200;
  // Control register fields
  localparam int C_RATE = 0;
  localparam int C_ODD  = 3;
  localparam int C_RXF  = 4;
  localparam int C_TXF  = 5;
  localparam int C_LOOP = 6;
  localparam int C_LONE = 8;
  localparam int C_LCH  = 9;
  // Highway modes and loop modes
  localparam logic [2:0] R2048 = 3'h0;
  localparam logic [2:0] R1544 = 3'h1;
  localparam logic [2:0] R1536 = 3'h2;
  localparam logic [2:0] R4096 = 3'h3;
  localparam logic [2:0] R3088 = 3'h4;
  localparam logic [2:0] R6176 = 3'h5;
  localparam logic [2:0] R8192 = 3'h6;
  localparam logic [1:0] LOOP_INT = 2'h1;
  localparam logic [1:0] LOOP_EXT = 2'h2;
  // Slot table fields
  localparam int S_CH   = 0;
  localparam int S_MASK = 5;
  localparam int S_RXEN = 13;
  localparam int S_TXEN = 14;
  // Channel configuration fields
  localparam int F_PROTO = 0;
  localparam int F_BASE  = 3;
  localparam int F_SIZE  = 9;
  localparam int F_FILL  = 15;
  localparam int F_ADJ   = 23;
  localparam int F_FLAG  = 24;
  // Transmit section select fields
  localparam int T_FE  = 5;
  localparam int T_LEN = 6;
  // Channel protocols, fill characters and V110 counts
  localparam logic [2:0] P_HDLC    = 3'h0;
  localparam logic [2:0] P_SLOT_TR = 3'h1;
  localparam logic [2:0] P_BIT_TRB = 3'h2;
  localparam logic [2:0] P_BIT_TRR = 3'h3;
  localparam logic [2:0] P_V110    = 3'h4;
  localparam logic [7:0] CH_FLAG  = 8'h7e;
  localparam logic [7:0] CH_ONES  = 8'hff;
  localparam logic [7:0] CH_ZERO  = 8'h00;
  localparam logic [11:0] V110_BITS = 12'h050;
  localparam logic [11:0] V110_TAIL = 12'h0a0;
  localparam logic [6:0] V110_LAST  = 7'h4f;
endpackage
`default_nettype wire

// ### rtl/mpcm_lane_if.sv
// Sampled highway lane events passed from a lane sampler to the core
`timescale 1ns/1ns
`default_nettype none
interface mpcm_lane_if;
  logic tick;
  logic fs;
  logic dat;
  modport src (output tick, fs, dat);
  modport dst (input tick, fs, dat);
endinterface
`default_nettype wire

// ### rtl/mpcm_lane.sv
// Samples one highway direction: bit clock, frame sync and data pins
`timescale 1ns/1ns
`default_nettype none
module mpcm_lane
  import mpcm_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic fall,
  input  wire logic bclk,
  input  wire logic sync,
  input  wire logic dat,
  mpcm_lane_if.src  lane
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] v;
    logic       tick;
    logic       fs;
    logic       dat;
  } mpcm_lane_st_t;

  mpcm_lane_st_t s;
  mpcm_lane_st_t n;

  always_comb begin
    n = s;
    n.s1 = {dat, sync, bclk};
    n.s2 = s.s1;
    n.s3 = s.s2;
    // A level counts only once two later stages agree
    for (int i = 0; i < 3; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        n.v[i] = s.s3[i];
      end
    end
    n.tick = fall ? (s.v[0] & ~n.v[0]) : (~s.v[0] & n.v[0]);
    n.fs = ~s.v[1] & n.v[1];
    n.dat = n.v[2];
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign lane.tick = s.tick;
  assign lane.fs = s.fs;
  assign lane.dat = s.dat;
endmodule
`default_nettype wire

// ### rtl/mpcm_core.sv
// Multichannel serial highway core with APB register access
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Thirty-two full-duplex channels, per-slot direction handling
// - Receive and transmit timing sampled independently
// - 2.048 with 32 slots, 1.544/1.536 with 24
// - 4.096 mode serves only even or odd slots
// - Extra modes 3.088, 6.176, 8.192 Mbit/s
// - Per-slot mask picks used bits; slots share channels
// - Rising or falling sampling edge per direction
// - Framing bit ignored on receive, tristated on transmit
// - Internal or external loop, all or one channel
// - Sync rising edge restarts frame position counters
// - One shared handler, context indexed per channel
// - Store 32 bits, then request the bus
// - Request data when a word frees up
// - 64-word transmit store, per-channel region and size
// - 64-word receive FIFO before shared memory
// - Fill sections, release them, report section done
// - Frame end: terminate then send fill characters
// - Slot-transparent frame end appends programmable flags
// - Fixed-frame end: zero-complete, two more zero frames
// - Optional fill reduction by stuffed zeros over eight
// - Fixed-frame abort raises maskable event before resuming
module mpcm_core
  import mpcm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        receive_bit_clock,
  input  wire logic        receive_frame_sync,
  input  wire logic        receive_data,
  input  wire logic        transmit_bit_clock,
  input  wire logic        transmit_frame_sync,
  output logic             transmit_data,
  output logic             transmit_data_oe,
  output logic             rx_bus_req,
  output logic             tx_bus_req,
  output logic             abort_int
);
  typedef struct packed {
    logic       ok;
    logic       first;
    logic [4:0] slot;
    logic [2:0] bit_no;
  } mpcm_map_t;

  typedef struct packed {
    logic [13:0]                ctrl;
    logic [NCH-1:0]             stat;
    logic [NCH-1:0]             mask;
    logic [NCH-1:0][14:0]       slot;
    logic [NCH-1:0][31:0]       chan;
    logic [10:0]                rxpos;
    logic [10:0]                txpos;
    logic [NCH-1:0][31:0]       racc;
    logic [NCH-1:0][4:0]        rcnt;
    logic [RB_DEPTH-1:0][36:0]  rbuf;
    logic [5:0]                 rwp;
    logic [5:0]                 rrp;
    logic [6:0]                 rnum;
    logic [TB_DEPTH-1:0][31:0]  tbuf;
    logic [NCH-1:0][5:0]        trd;
    logic [NCH-1:0][6:0]        tnum;
    logic [NCH-1:0][4:0]        tbit;
    logic [NCH-1:0][2:0]        ones;
    logic [NCH-1:0][7:0]        stuf;
    logic [NCH-1:0][11:0]       fill;
    logic [NCH-1:0]             fillc;
    logic [NCH-1:0]             fep;
    logic [NCH-1:0][6:0]        vbit;
    logic [12:0]                tsel;
    logic [NCH-1:0]             tdone;
    logic                       txd;
    logic                       txoe;
    logic                       rxreq;
    logic                       txreq;
    logic                       irq;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
  } mpcm_st_t;

  mpcm_st_t s;
  mpcm_st_t n;

  mpcm_lane_if rl ();
  mpcm_lane_if tl ();

  // Two samplers keep the directions apart in phase and frame
  mpcm_lane u_rx (
    .clock (clock),
    .rst_b (rst_b),
    .fall  (s.ctrl[C_RXF]),
    .bclk  (receive_bit_clock),
    .sync  (receive_frame_sync),
    .dat   (receive_data),
    .lane  (rl)
  );

  mpcm_lane u_tx (
    .clock (clock),
    .rst_b (rst_b),
    .fall  (s.ctrl[C_TXF]),
    .bclk  (transmit_bit_clock),
    .sync  (transmit_frame_sync),
    .dat   (1'b0),
    .lane  (tl)
  );

  ////////////////////////////////////////////////////////////////////////
  // Frame position to slot and bit; faster modes act on the first edge
  function automatic mpcm_map_t slot_map(logic [2:0] r, logic odd,
                                         logic [10:0] p);
    mpcm_map_t   o;
    logic [1:0]  sh;
    logic [10:0] b;
    o = '0;
    sh = (r == R3088) ? 2'd1 : (r == R6176 || r == R8192) ? 2'd2 : 2'd0;
    b = p >> sh;
    o.first = (p & ((11'd1 << sh) - 11'd1)) == 11'd0;
    // Framing bit wraps b high, so it never maps to a slot
    if (r == R1544 || r == R3088 || r == R6176) begin
      b = b - 11'd1;
    end
    o.bit_no = b[2:0];
    if (r == R4096) begin
      o.ok = (b[10:3] < 8'd64) && (b[3] == odd);
      o.slot = b[8:4];
    end else begin
      o.ok = b[10:3] < ((r == R2048 || r == R8192) ? 8'd32 : 8'd24);
      o.slot = b[7:3];
    end
    o.ok = o.ok && o.first;
    return o;
  endfunction

  function automatic logic [7:0] size_of(logic [31:0] cfg);
    return {2'b00, cfg[F_SIZE+:6]} + 8'd1;
  endfunction

  // Word slot inside a channel's own region of the transmit store
  function automatic logic [5:0] ring(logic [31:0] cfg, logic [7:0] idx);
    logic [7:0] i;
    i = idx;
    if (i >= size_of(cfg)) begin
      i = i - size_of(cfg);
    end
    return cfg[F_BASE+:6] + i[5:0];
  endfunction

  function automatic logic [7:0] fill_char(logic [31:0] cfg, logic idle);
    case (cfg[F_PROTO+:3])
      P_HDLC:    fill_char = CH_FLAG;
      P_SLOT_TR: fill_char = idle ? CH_ONES : cfg[F_FLAG+:8];
      default:   fill_char = CH_ZERO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    mpcm_map_t   m;
    logic [4:0]  c;
    logic [4:0]  idx;
    logic [4:0]  tch;
    logic [5:0]  a;
    logic [7:0]  ch8;
    logic [7:0]  t8;
    logic [7:0]  fc;
    logic [7:0]  sub;
    logic [10:0] p;
    logic [11:0] f;
    logic [31:0] cfg;
    logic [31:0] wd;
    logic [31:0] rd;
    logic [NCH-1:0] free;
    logic        d;
    logic        hit;
    logic        err;
    n = s;
    m = '0;
    c = '0;
    idx = paddr[6:2];
    tch = s.tsel[4:0];
    a = '0;
    ch8 = '0;
    t8 = '0;
    fc = '0;
    sub = '0;
    p = '0;
    f = '0;
    cfg = '0;
    wd = '0;
    rd = '0;
    free = '0;
    d = 1'b0;
    hit = 1'b1;
    err = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      free[i] = {1'b0, s.tnum[i]} < size_of(s.chan[i]);
    end

    //////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, effects at the edge with pready high
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (paddr[11:7] == A_SLOT[11:7]) begin
      rd = {17'h0, s.slot[idx]};
    end else if (paddr[11:7] == A_CHAN[11:7]) begin
      rd = s.chan[idx];
    end else begin
      case (paddr)
        A_CTRL:   rd = {18'h0, s.ctrl};
        A_STAT:   rd = s.stat;
        A_MASK:   rd = s.mask;
        A_RXCNT:  rd = {25'h0, s.rnum};
        A_RXDATA: rd = s.rbuf[s.rrp][31:0];
        A_RXCH:   rd = {27'h0, s.rbuf[s.rrp][36:32]};
        A_TXREQ:  rd = free;
        A_TXDATA: rd = '0;
        A_TXSEL:  rd = {19'h0, s.tsel};
        A_TXDONE: rd = s.tdone;
        default:  hit = 1'b0;
      endcase
    end
    err = !hit || (pwrite && paddr == A_TXDATA &&
                   !(free[tch] && s.tsel[T_LEN+:7] != 7'd0));
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      n.pready = 1'b1;
      n.pslverr = err;
      n.prdata = (err || pwrite) ? 32'h0 : rd;
    end
    if (psel && penable && s.pready && !err) begin
      if (!pwrite) begin
        if (paddr == A_RXDATA && s.rnum != 7'd0) begin
          n.rrp = s.rrp + 6'd1;
          n.rnum = s.rnum - 7'd1;
        end
      end else if (paddr[11:7] == A_SLOT[11:7]) begin
        n.slot[idx] = pwdata[14:0];
      end else if (paddr[11:7] == A_CHAN[11:7]) begin
        // Only this channel's transmit state restarts
        n.chan[idx] = pwdata;
        n.trd[idx] = '0;
        n.tnum[idx] = '0;
        n.tbit[idx] = '0;
        n.ones[idx] = '0;
        n.fillc[idx] = 1'b0;
        n.fep[idx] = 1'b0;
      end else begin
        case (paddr)
          A_CTRL:   n.ctrl = pwdata[13:0];
          A_STAT:   n.stat = s.stat & ~pwdata;
          A_MASK:   n.mask = pwdata;
          A_TXSEL:  n.tsel = pwdata[12:0];
          A_TXDONE: n.tdone = s.tdone & ~pwdata;
          A_TXDATA: begin
            a = ring(s.chan[tch], {2'b00, s.trd[tch]} + {1'b0, s.tnum[tch]});
            n.tbuf[a] = pwdata;
            n.tnum[tch] = s.tnum[tch] + 7'd1;
            n.tsel[T_LEN+:7] = s.tsel[T_LEN+:7] - 7'd1;
            // Last word of a section releases it
            if (s.tsel[T_LEN+:7] == 7'd1) begin
              n.tdone[tch] = 1'b1;
              n.fep[tch] = s.tsel[T_FE];
            end
          end
          default: ;
        endcase
      end
    end

    //////////////////////////////////////////////////////////////////////
    // Receive: shared deformatter works on the slot's channel context
    if (rl.tick) begin
      p = rl.fs ? 11'd0 : s.rxpos;
      n.rxpos = p + 11'd1;
      m = slot_map(s.ctrl[C_RATE+:3], s.ctrl[C_ODD], p);
      c = s.slot[m.slot][S_CH+:5];
      d = (s.ctrl[C_LOOP+:2] == LOOP_INT &&
           (!s.ctrl[C_LONE] || c == s.ctrl[C_LCH+:5])) ? s.txd : rl.dat;
      if (m.ok && s.slot[m.slot][S_RXEN] &&
          s.slot[m.slot][S_MASK + m.bit_no]) begin
        n.racc[c][s.rcnt[c]] = d;
        n.rcnt[c] = s.rcnt[c] + 5'd1;
        // A full word goes to the FIFO; a full FIFO drops it
        if (s.rcnt[c] == 5'd31 && n.rnum < 7'(RB_DEPTH)) begin
          n.rbuf[n.rwp] = {c, n.racc[c]};
          n.rwp = n.rwp + 6'd1;
          n.rnum = n.rnum + 7'd1;
        end
      end
    end else if (rl.fs) begin
      n.rxpos = '0;
    end

    //////////////////////////////////////////////////////////////////////
    // Transmit: shared formatter drives one bit per active slot bit
    if (tl.tick) begin
      p = tl.fs ? 11'd0 : s.txpos;
      n.txpos = p + 11'd1;
      m = slot_map(s.ctrl[C_RATE+:3], s.ctrl[C_ODD], p);
      c = s.slot[m.slot][S_CH+:5];
      cfg = s.chan[c];
      ch8 = fill_char(cfg, !s.fillc[c]);
      if (m.first) begin
        n.txoe = 1'b0;
      end
      if (m.ok && s.slot[m.slot][S_TXEN] &&
          s.slot[m.slot][S_MASK + m.bit_no]) begin
        n.txoe = 1'b1;
        if (s.ctrl[C_LOOP+:2] == LOOP_EXT &&
            (!s.ctrl[C_LONE] || c == s.ctrl[C_LCH+:5])) begin
          n.txd = rl.dat;
        end else if (s.fillc[c]) begin
          f = s.fill[c] - 12'd1;
          n.txd = ch8[~f[2:0]];
          n.fill[c] = f;
          if (f == 12'd0) begin
            n.fillc[c] = 1'b0;
            if (cfg[F_PROTO+:3] == P_V110) begin
              n.stat[c] = 1'b1;
            end
          end
        end else if (n.tnum[c] != 7'd0) begin
          a = ring(cfg, {2'b00, n.trd[c]});
          wd = s.tbuf[a];
          if (cfg[F_PROTO+:3] == P_HDLC && s.ones[c] == 3'd5) begin
            n.txd = 1'b0;
            n.ones[c] = '0;
            n.stuf[c] = s.stuf[c] + 8'd1;
          end else begin
            n.txd = wd[s.tbit[c]];
            n.ones[c] = wd[s.tbit[c]] ? s.ones[c] + 3'd1 : 3'd0;
            n.tbit[c] = s.tbit[c] + 5'd1;
            n.vbit[c] = (s.vbit[c] == V110_LAST) ? 7'd0 : s.vbit[c] + 7'd1;
            if (s.tbit[c] == 5'd31) begin
              t8 = {2'b00, n.trd[c]} + 8'd1;
              n.trd[c] = (t8 == size_of(cfg)) ? 6'd0 : t8[5:0];
              n.tnum[c] = n.tnum[c] - 7'd1;
              if (n.tnum[c] == 7'd0 && s.fep[c]) begin
                n.fep[c] = 1'b0;
                if (cfg[F_PROTO+:3] == P_V110) begin
                  // Finish this 10-octet frame, then two zero frames
                  n.fill[c] = V110_BITS - {5'h0, n.vbit[c]} + V110_TAIL;
                end else begin
                  sub = cfg[F_ADJ] ? (n.stuf[c] >> 3) : 8'd0;
                  fc = cfg[F_FILL+:8];
                  fc = (fc > sub) ? fc - sub : 8'd0;
                  n.fill[c] = {1'b0, fc, 3'b000};
                end
                n.stuf[c] = '0;
                n.fillc[c] = n.fill[c] != 12'd0;
              end
            end
          end
        end else begin
          n.txd = ch8[m.bit_no];
        end
      end
    end else if (tl.fs) begin
      n.txpos = '0;
    end

    n.rxreq = n.rnum != 7'd0;
    n.txreq = |free;
    n.irq = |(n.stat & n.mask);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign transmit_data = s.txd;
  assign transmit_data_oe = s.txoe;
  assign rx_bus_req = s.rxreq;
  assign tx_bus_req = s.txreq;
  assign abort_int = s.irq;
endmodule
`default_nettype wire

// ### bench/mpcm_core_checker.sv
// Port assertions for the serial highway core
`timescale 1ns/1ns
`default_nettype none
module mpcm_core_checker
  import mpcm_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        transmit_bit_clock,
  input wire logic        transmit_data,
  input wire logic        transmit_data_oe,
  input wire logic        rx_bus_req,
  input wire logic        abort_int
);
  logic       tclk_q;
  logic [3:0] tcnt;
  logic       pop;
  logic       sm_wr;
  assign pop = pready && psel && !pwrite && paddr == A_RXDATA;
  assign sm_wr = pready && pwrite && (paddr == A_STAT || paddr == A_MASK);
  // Cycles since the transmit clock pin rose; saturates so idle is legal
  always_ff @(posedge clock) begin
    tclk_q <= transmit_bit_clock;
    if (!rst_b)
      tcnt <= 4'hf;
    else if (transmit_bit_clock && !tclk_q)
      tcnt <= 4'h0;
    else if (tcnt != 4'hf)
      tcnt <= tcnt + 4'h1;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_access_start;
    psel && $rose(penable);
  endsequence
  sequence s_ready_late;
    !pready ##1 pready;
  endsequence
  a_ready_after_access: assert property (s_access_start |-> s_ready_late)
    else $error("pready not in second access cycle");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_misaligned_error: assert property (pready && paddr[1:0] != 2'h0 |->
    pslverr) else $error("misaligned access not refused");
  a_quiet_read_data: assert property (pready && (pwrite || pslverr) |->
    prdata == 32'h0) else $error("read data not zero");
  a_rxreq_on_pop: assert property ($fell(rx_bus_req) |->
    $past(pop, 1) || $past(pop, 2) || $past(pop, 3))
    else $error("receive request dropped without a pop");
  a_txout_on_edge: assert property (
    $changed(transmit_data) || $changed(transmit_data_oe) |->
    tcnt inside {[4'h1:4'h6]}) else $error("transmit pin off its edge");
  a_abort_drop_write: assert property ($fell(abort_int) |->
    $past(sm_wr, 1) || $past(sm_wr, 2) || $past(sm_wr, 3))
    else $error("abort event dropped without a write");
endmodule
bind mpcm_core mpcm_core_checker mpcm_core_checker_inst (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .transmit_bit_clock(transmit_bit_clock),
  .transmit_data(transmit_data), .transmit_data_oe(transmit_data_oe),
  .rx_bus_req(rx_bus_req), .abort_int(abort_int)
);
`default_nettype wire

// ### bench/mpcm_highway_model.sv
// Behavioural highway partner: bit clocks, syncs and transmit capture
`timescale 1ns/1ns
`default_nettype none
module mpcm_highway_model (
  input  wire logic         run,
  input  wire logic [7:0]   pattern,
  input  wire logic         transmit_data,
  input  wire logic         transmit_data_oe,
  output logic              receive_bit_clock,
  output logic              receive_frame_sync,
  output logic              receive_data,
  output logic              transmit_bit_clock,
  output logic              transmit_frame_sync,
  output logic      [127:0] tx_hist,
  output logic      [8:0]   oe_bits
);
  int rpos;
  int tpos;
  int ocnt;
  // Data and sync move on the falling edge; the device samples rising
  initial begin
    receive_bit_clock = 1'b0;
    receive_frame_sync = 1'b0;
    receive_data = 1'b0;
    rpos = 0;
    wait (run);
    #25;
    forever begin
      receive_frame_sync = (rpos == 0);
      receive_data = pattern[7 - rpos % 8];
      #400 receive_bit_clock = 1'b1;
      #400 receive_bit_clock = 1'b0;
      rpos = (rpos + 1) % 256;
    end
  end
  // Own phase, so the two directions never line up
  initial begin
    transmit_bit_clock = 1'b0;
    transmit_frame_sync = 1'b0;
    tx_hist = '0;
    oe_bits = '0;
    tpos = 0;
    ocnt = 0;
    wait (run);
    #350;
    forever begin
      transmit_bit_clock = 1'b1;
      #400 transmit_bit_clock = 1'b0;
      transmit_frame_sync = (tpos == 254);
      // Sample late in the bit, after the device has moved its output
      #300;
      if (transmit_data_oe === 1'b1) begin
        ocnt++;
        tx_hist = {transmit_data, tx_hist[127:1]};
      end
      #100;
      tpos = (tpos + 1) % 256;
      if (tpos == 0) begin
        oe_bits = 9'(ocnt);
        ocnt = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the serial highway core
`timescale 1ns/1ns
`default_nettype none
module tb;
  import mpcm_pkg::*;
  localparam int          FRAME = 2048;
  localparam logic [7:0]  PAT = 8'h35;
  localparam logic [31:0] WORD = 32'h1234_5678;
  logic         clock = 1'b0;
  logic         rst_b = 1'b0;
  logic         run = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata, rdat;
  logic         pready, pslverr, rerr, rx_bus_req, tx_req, abort_int;
  logic         rx_clk, rx_sync, rx_dat, tx_clk, tx_sync, tx_dat, tx_oe;
  logic [127:0] tx_hist;
  logic [8:0]   oe_bits;
  int           fail_count = 0;
  int           n_checks = 0;
  always #50 clock = ~clock;
  mpcm_core mpcm_core_inst (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_bit_clock(rx_clk), .receive_frame_sync(rx_sync),
    .receive_data(rx_dat), .transmit_bit_clock(tx_clk),
    .transmit_frame_sync(tx_sync), .transmit_data(tx_dat),
    .transmit_data_oe(tx_oe), .rx_bus_req(rx_bus_req), .tx_bus_req(tx_req),
    .abort_int(abort_int));
  mpcm_highway_model mpcm_highway_model_inst (.run(run), .pattern(PAT),
    .transmit_data(tx_dat), .transmit_data_oe(tx_oe),
    .receive_bit_clock(rx_clk), .receive_frame_sync(rx_sync),
    .receive_data(rx_dat), .transmit_bit_clock(tx_clk),
    .transmit_frame_sync(tx_sync), .tx_hist(tx_hist), .oe_bits(oe_bits));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    check({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_errors;
    apb(1'b0, 12'h030, 32'h0);
    check({31'h0, rerr}, 32'h1);
    apb(1'b1, 12'h002, 32'h0);
    check({31'h0, rerr}, 32'h1);
    // A zero-length section leaves no room for data
    apb(1'b1, A_TXSEL, 32'h5);
    apb(1'b1, A_TXDATA, 32'h1);
    check({31'h0, rerr}, 32'h1);
  endtask
  task automatic t_rx_fifo;
    logic [31:0] exp;
    for (int k = 0; k < 32; k++)
      exp[k] = PAT[7 - k % 8];
    for (int s = 0; s < NCH; s++)
      apb(1'b1, A_SLOT + 12'(4 * s), 32'(s) | 32'h3fe0);
    // Highway starts only now, so every channel's words begin on bit 0
    run <= 1'b1;
    // Ten frames carry eighty words of bits but complete only two words per channel, so the store fills to exactly 64
    repeat (10 * FRAME) @(posedge clock);
    apb(1'b0, A_RXCNT, 32'h0);
    check(rdat, 32'd64);
    check({31'h0, rx_bus_req}, 32'h1);
    for (int s = 0; s < NCH; s++)
      apb(1'b1, A_SLOT + 12'(4 * s), 32'h0);
    repeat (64) begin
      apb(1'b0, A_RXDATA, 32'h0);
      check(rdat, exp);
    end
    repeat (4) @(posedge clock);
    check({31'h0, rx_bus_req}, 32'h0);
  endtask
  task automatic t_tx;
    logic hit;
    apb(1'b1, A_CHAN + 12'h014, 32'h201);
    apb(1'b1, A_SLOT + 12'h008, 32'h5fe5);
    apb(1'b1, A_TXSEL, 32'h45);
    apb(1'b1, A_TXDATA, WORD);
    check({31'h0, rerr}, 32'h0);
    repeat (2) @(posedge clock);
    check({31'h0, tx_req}, 32'h1);
    repeat (7 * FRAME) @(posedge clock);
    check({23'h0, oe_bits}, 32'd8);
    hit = 1'b0;
    for (int i = 0; i <= 96; i++)
      if (tx_hist[i +: 32] === WORD)
        hit = 1'b1;
    check({31'h0, hit}, 32'h1);
    apb(1'b0, A_TXDONE, 32'h0);
    check({31'h0, rdat[5]}, 32'h1);
    apb(1'b1, A_TXDONE, 32'h20);
    apb(1'b0, A_TXDONE, 32'h0);
    check({31'h0, rdat[5]}, 32'h0);
  endtask
  task automatic t_v110;
    apb(1'b1, A_MASK, 32'h0);
    apb(1'b1, A_CHAN + 12'h014, 32'h204);
    for (int s = 3; s < 6; s++)
      apb(1'b1, A_SLOT + 12'(4 * s), 32'h5fe5);
    apb(1'b1, A_TXSEL, 32'h65);
    apb(1'b1, A_TXDATA, WORD);
    repeat (12 * FRAME) @(posedge clock);
    check({23'h0, oe_bits}, 32'd32);
    apb(1'b0, A_STAT, 32'h0);
    check({31'h0, rdat[5]}, 32'h1);
    check({31'h0, abort_int}, 32'h0);
    apb(1'b1, A_MASK, 32'h20);
    repeat (3) @(posedge clock);
    check({31'h0, abort_int}, 32'h1);
    apb(1'b1, A_STAT, 32'h20);
    repeat (3) @(posedge clock);
    check({31'h0, abort_int}, 32'h0);
  endtask
  task automatic conclude;
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_errors;
    t_rx_fifo;
    t_tx;
    t_v110;
    conclude;
  end
  initial begin
    repeat (90000) @(posedge clock);
    fail_count++;
    conclude;
  end
endmodule
`default_nettype wire
